// ===== pscl_map.svh
`ifndef PSCL_MAP_SVH
`define PSCL_MAP_SVH
`define PSCL_ADDR_W 5
`define PSCL_ADDR_RESET 5'h00
`define PSCL_MODE_RESET 3'h0
`define PSCL_MODE_10HD 3'h0
`define PSCL_MODE_10FD 3'h1
`define PSCL_MODE_100HD 3'h2
`define PSCL_MODE_100FD 3'h3
`define PSCL_MODE_AN100HD 3'h4
`define PSCL_MODE_REPEATER 3'h5
`define PSCL_MODE_PWRDN 3'h6
`define PSCL_MODE_ALL 3'h7
`define PSCL_ADV_100HD 4'h4
`define PSCL_ADV_ALL 4'hF
`define PSCL_ADV_RESET 4'hF
`define PSCL_CTL_RESET 4'h0
`endif

// ===== pscl_pkg.sv
`include "pscl_map.svh"
package pscl_pkg;
    // control bits 13,12,10,8 of the basic control register
    typedef struct packed {
        logic speed_100;
        logic autoneg_en;
        logic power_down;
        logic full_duplex;
    } pscl_ctl_s;
    // strap levels as sensed on the shared receive pins
    typedef struct packed {
        logic rxer_addr;
        logic crs_dv_mode2;
        logic rxd1_mode1;
        logic rxd0_mode0;
    } pscl_strap_s;
    // management write requests into the config registers
    typedef struct packed {
        logic addr_we;
        logic [4:0] addr;
        logic mode_we;
        logic [2:0] mode;
        logic ctl_we;
        logic [3:0] ctl;
        logic adv_we;
        logic [3:0] adv;
        logic soft_reset;
    } pscl_wr_s;
    typedef enum logic [1:0] {
        PSCL_ST_RESET = 2'b00,
        PSCL_ST_SETTLE = 2'b01,
        PSCL_ST_RUN = 2'b10
    } pscl_state_e;
endpackage : pscl_pkg

// ===== pscl_strap_loader.sv
`timescale 1ns/10ps
`include "pscl_map.svh"
module pscl_strap_loader (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_pin_reset_n,
    input wire pscl_pkg::pscl_strap_s i_strap_pins,
    input wire pscl_pkg::pscl_wr_s i_mgmt_wr,
    input wire logic [4:0] i_frame_addr,
    input wire logic i_frame_valid,
    output logic [4:0] o_management_address_field,
    output logic [2:0] o_mode,
    output pscl_pkg::pscl_ctl_s o_ctl,
    output logic [3:0] o_adv,
    output logic o_repeater,
    output logic o_crs_on_tx,
    output logic o_frame_match,
    output logic [10:0] o_scrambler_seed,
    output logic o_strap_pins_oe,
    output logic o_core_reset
);
    import pscl_pkg::*;

    // pins come from the board: two flops before use
    pscl_strap_s strap_meta;
    pscl_strap_s strap_sync;
    logic prst_meta;
    logic prst_sync;

    pscl_state_e state;
    pscl_state_e next_state;
    logic [4:0] addr;
    logic [4:0] next_addr;
    logic [2:0] mode;
    logic [2:0] next_mode;
    pscl_ctl_s ctl;
    pscl_ctl_s next_ctl;
    logic [3:0] adv;
    logic [3:0] next_adv;
    logic match;
    logic next_match;
    logic core_rst;
    logic next_core_rst;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strap_meta <= '0;
            strap_sync <= '0;
            prst_meta <= 1'b0;
            prst_sync <= 1'b0;
        end else begin
            strap_meta <= i_strap_pins;
            strap_sync <= strap_meta;
            prst_meta <= i_pin_reset_n;
            prst_sync <= prst_meta;
        end
    end

    // decoded defaults for a mode code
    function automatic pscl_ctl_s mode_ctl(input logic [2:0] m, input pscl_ctl_s cur);
        pscl_ctl_s c;
        c = cur;
        unique case (m)
            `PSCL_MODE_10HD: c = 4'b0000;
            `PSCL_MODE_10FD: c = 4'b0001;
            `PSCL_MODE_100HD: c = 4'b1000;
            `PSCL_MODE_100FD: c = 4'b1001;
            `PSCL_MODE_AN100HD: c = 4'b1100;
            `PSCL_MODE_REPEATER: c = 4'b1100;
            `PSCL_MODE_PWRDN: c.power_down = 1'b1;
            // don't-care speed/duplex kept at their current value
            `PSCL_MODE_ALL: begin
                c.autoneg_en = 1'b1;
                c.power_down = 1'b0;
            end
        endcase
        return c;
    endfunction : mode_ctl

    function automatic logic [3:0] mode_adv(input logic [2:0] m, input logic [3:0] cur);
        logic [3:0] a;
        a = cur;
        if (m == `PSCL_MODE_AN100HD || m == `PSCL_MODE_REPEATER) begin
            a = `PSCL_ADV_100HD;
        end else if (m == `PSCL_MODE_ALL) begin
            a = `PSCL_ADV_ALL;
        end
        return a;
    endfunction : mode_adv

    always_comb begin
        next_state = state;
        next_addr = addr;
        next_mode = mode;
        next_ctl = ctl;
        next_adv = adv;
        next_core_rst = core_rst;
        next_match = i_frame_valid && (i_frame_addr == addr);
        unique case (state)
            // pin reset held: pins are inputs, core held
            PSCL_ST_RESET: begin
                next_core_rst = 1'b1;
                if (prst_sync) begin
                    next_state = PSCL_ST_SETTLE;
                end
            end
            // release edge: latch straps and load defaults
            PSCL_ST_SETTLE: begin
                next_addr = {4'h0, strap_sync.rxer_addr};
                next_mode = {strap_sync.crs_dv_mode2, strap_sync.rxd1_mode1,
                             strap_sync.rxd0_mode0};
                next_ctl = mode_ctl(next_mode, ctl);
                next_adv = mode_adv(next_mode, adv);
                next_core_rst = 1'b0;
                next_state = PSCL_ST_RUN;
            end
            PSCL_ST_RUN: begin
                if (i_mgmt_wr.addr_we) begin
                    next_addr = i_mgmt_wr.addr;
                end
                if (i_mgmt_wr.mode_we) begin
                    next_mode = i_mgmt_wr.mode;
                end
                if (i_mgmt_wr.ctl_we) begin
                    next_ctl = i_mgmt_wr.ctl;
                end
                if (i_mgmt_wr.adv_we) begin
                    next_adv = i_mgmt_wr.adv;
                end
                // soft reset reapplies the register mode field, never the straps
                if (i_mgmt_wr.soft_reset) begin
                    next_ctl = mode_ctl(next_mode, next_ctl);
                    next_adv = mode_adv(next_mode, next_adv);
                    if (next_mode != `PSCL_MODE_PWRDN) begin
                        next_ctl.power_down = 1'b0;
                    end
                end
                if (!prst_sync) begin
                    next_state = PSCL_ST_RESET;
                end
            end
            default: next_state = PSCL_ST_RESET;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            // power-on: start from reset state; straps latched on its release
            state <= PSCL_ST_RESET;
            addr <= `PSCL_ADDR_RESET;
            mode <= `PSCL_MODE_RESET;
            ctl <= `PSCL_CTL_RESET;
            adv <= `PSCL_ADV_RESET;
            match <= 1'b0;
            core_rst <= 1'b1;
        end else begin
            state <= next_state;
            addr <= next_addr;
            mode <= next_mode;
            ctl <= next_ctl;
            adv <= next_adv;
            match <= next_match;
            core_rst <= next_core_rst;
        end
    end

    assign o_management_address_field = addr;
    assign o_mode = mode;
    assign o_ctl = ctl;
    assign o_adv = adv;
    assign o_repeater = (mode == `PSCL_MODE_REPEATER);
    // carrier sense on transmit only in half duplex, never for repeater
    assign o_crs_on_tx = !ctl.full_duplex && !o_repeater;
    assign o_frame_match = match;
    // address in low bits gives each device its own scrambler phase
    assign o_scrambler_seed = {6'h01, addr};
    assign o_strap_pins_oe = (state == PSCL_ST_RUN);
    assign o_core_reset = core_rst;
endmodule : pscl_strap_loader

// ===== pscl_monitor.sv
`timescale 1ns/10ps
module pscl_monitor (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_pin_reset_n,
    input wire pscl_pkg::pscl_wr_s i_mgmt_wr,
    input wire logic [4:0] i_frame_addr,
    input wire logic i_frame_valid,
    input wire logic [4:0] o_management_address_field,
    input wire logic [2:0] o_mode,
    input wire pscl_pkg::pscl_ctl_s o_ctl,
    input wire logic o_crs_on_tx,
    input wire logic o_frame_match,
    input wire logic [10:0] o_scrambler_seed,
    input wire logic o_strap_pins_oe
);
    import pscl_pkg::*;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    sequence s_hit;
        i_frame_valid && i_frame_addr == o_management_address_field && o_strap_pins_oe;
    endsequence
    sequence s_pin_low;
        !i_pin_reset_n [*4];
    endsequence
    a_match_own: assert property (s_hit |=> o_frame_match) else $error("missed match");
    a_match_only: assert property (o_frame_match |-> $past(i_frame_valid)
        && $past(i_frame_addr) == $past(o_management_address_field)) else $error("bad match");
    a_seed_addr: assert property (o_scrambler_seed[4:0] == o_management_address_field)
        else $error("seed");
    a_strap_addr: assert property ($rose(o_strap_pins_oe)
        |-> o_management_address_field[4:1] == 4'h0) else $error("strap address");
    a_pin_reset: assert property (s_pin_low |-> !o_strap_pins_oe) else $error("pin oe");
    a_addr_write: assert property (i_mgmt_wr.addr_we && o_strap_pins_oe && i_pin_reset_n
        |=> o_management_address_field == $past(i_mgmt_wr.addr)) else $error("addr write");
    a_crs_mode: assert property (o_crs_on_tx == (!o_ctl.full_duplex && o_mode != 3'h5))
        else $error("crs");
    a_soft_keep: assert property (i_mgmt_wr.soft_reset && !i_mgmt_wr.mode_we
        && o_strap_pins_oe && i_pin_reset_n |=> $stable(o_mode)) else $error("soft reset");
endmodule : pscl_monitor
bind pscl_strap_loader pscl_monitor mon (.*);

// ===== pscl_board.sv
`timescale 1ns/10ps
module pscl_board (
    input wire logic i_clk_sys,
    input wire logic i_strap_oe,
    input wire pscl_pkg::pscl_strap_s i_level,
    output pscl_pkg::pscl_strap_s o_pins
);
    import pscl_pkg::*;
    pscl_strap_s last;
    // pulls settle the pin while it is an input; once driven, show junk so a late latch shows
    always @(posedge i_clk_sys) last <= i_strap_oe ? ~last : i_level;
    assign o_pins = i_strap_oe ? last : i_level;
endmodule : pscl_board

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
    import pscl_pkg::*;
    logic i_clk_sys = 0, i_rst_b = 0, i_pin_reset_n = 1, i_frame_valid = 0, oe, rep, crs, hit, crst;
    logic [4:0] i_frame_addr = 0, addr;
    logic [2:0] mode;
    logic [3:0] adv;
    logic [18:0] e;
    logic [18:0] q[$];
    logic [31:0] lfsr = 32'h3CAA7007;
    pscl_ctl_s ctl;
    pscl_strap_s level = '0, pins;
    pscl_wr_s i_mgmt_wr = '0, w;
    int n_mismatch = 0, tests_run = 0;
    always #20 i_clk_sys = ~i_clk_sys;
    pscl_board board (.i_clk_sys(i_clk_sys), .i_strap_oe(oe), .i_level(level), .o_pins(pins));
    pscl_strap_loader dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_pin_reset_n(i_pin_reset_n),
        .i_strap_pins(pins), .i_mgmt_wr(i_mgmt_wr), .i_frame_addr(i_frame_addr),
        .i_frame_valid(i_frame_valid), .o_management_address_field(addr), .o_mode(mode),
        .o_ctl(ctl), .o_adv(adv), .o_repeater(rep), .o_crs_on_tx(crs), .o_frame_match(hit),
        .o_scrambler_seed(), .o_strap_pins_oe(oe), .o_core_reset(crst));
    function automatic logic [31:0] rnd(input logic [31:0] s);
        rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : rnd
    function automatic logic [18:0] ex(input logic [4:0] a, input logic [2:0] m,
        input logic [3:0] c, input logic [3:0] v, input logic h);
        ex = {a, m, c, v, m == 3'h5, !c[0] && m != 3'h5, h};
    endfunction : ex
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [18:0] seen, input logic [18:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value outputs expected %h seen %h", exp, seen);
        end
    endtask : check
    // one cycle of stimulus; its result is checked at the next falling edge
    task automatic step(input pscl_wr_s wr, input logic v, input logic [4:0] fa,
        input logic [18:0] x);
        i_mgmt_wr <= wr;
        i_frame_valid <= v;
        i_frame_addr <= fa;
        q.push_back(x);
        @(negedge i_clk_sys);
    endtask : step
    task automatic boot(input logic po, input logic [2:0] m, input logic a);
        level <= '{a, m[2], m[1], m[0]};
        if (po) i_rst_b <= 0;
        else i_pin_reset_n <= 0;
        repeat (5) @(negedge i_clk_sys);
        check({18'h0, crst}, 19'h1);
        i_rst_b <= 1;
        i_pin_reset_n <= 1;
        for (int k = 0; k < 20 && oe !== 1'b1; k++) @(negedge i_clk_sys);
        if (oe !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
        check({18'h0, crst}, 19'h0);
    endtask : boot
    always @(posedge i_clk_sys) if (q.size() > 0) begin
        @(negedge i_clk_sys);
        check({addr, mode, ctl, adv, rep, crs, hit}, q.pop_front());
    end
    initial begin
        for (int m = 0; m < 8; m++) begin
            lfsr = rnd(lfsr);
            boot(1, m[2:0], lfsr[0]);
            e = ex({4'h0, lfsr[0]}, m[2:0], m < 4 ? {m[1], 2'b00, m[0]} : m < 6 ? 4'hC
                : m == 6 ? 4'h2 : 4'h4, m inside {4, 5} ? 4'h4 : 4'hF, 0);
            step('0, 1, e[18:14], e | 19'h1);
            step('0, 1, e[18:14] ^ 5'h01, e);
            step('0, 0, 0, e);
        end
        $display("strap load done");
        boot(0, 3'h2, 1);
        step('0, 0, 0, ex(5'h01, 3'h2, 4'h8, 4'hF, 0));
        lfsr = rnd(lfsr);
        w = '0;
        w.addr_we = 1;
        w.addr = lfsr[4:0];
        step(w, 0, 0, ex(lfsr[4:0], 3'h2, 4'h8, 4'hF, 0));
        step('0, 1, lfsr[4:0], ex(lfsr[4:0], 3'h2, 4'h8, 4'hF, 1));
        w = '{mode_we: 1, mode: 3'h7, soft_reset: 1, default: '0};
        step(w, 0, 0, ex(lfsr[4:0], 3'h7, 4'hC, 4'hF, 0));
        w = '{ctl_we: 1, ctl: lfsr[8:5], adv_we: 1, adv: lfsr[12:9], default: '0};
        step(w, 0, 0, ex(lfsr[4:0], 3'h7, lfsr[8:5], lfsr[12:9], 0));
        $display("management writes done");
        boot(1, 3'h6, 0);
        level <= '0;
        w = '{mode_we: 1, mode: 3'h4, soft_reset: 1, default: '0};
        step(w, 0, 0, ex(5'h00, 3'h4, 4'hC, 4'h4, 0));
        w = '{soft_reset: 1, default: '0};
        step(w, 0, 0, ex(5'h00, 3'h4, 4'hC, 4'h4, 0));
        step('0, 0, 0, ex(5'h00, 3'h4, 4'hC, 4'h4, 0));
        $display("power down exit done");
        // let the watcher take the last note before the verdict
        repeat (2) @(negedge i_clk_sys);
        tally_and_finish();
    end
endmodule : testbench
